// [core/status_flags_cfg.svh]
// Purpose: Constants for the thermal and fan status flag bank
// Assumes: 8-bit status registers, 8-bit temperatures and 16-bit counts
// Notes:   Bit positions match the two status register layouts
`ifndef STATUS_FLAGS_CFG_SVH
`define STATUS_FLAGS_CFG_SVH

`define LIMIT_FAN_STATUS_ADDR  8'h02
`define CRITICAL_STATUS_ADDR   8'h03
`define STATUS_RESET           8'h00

`define BIT_REMOTE_LOW         3
`define BIT_REMOTE_HIGH        2
`define BIT_FAN_SLOW           1
`define BIT_OVERSPEED          0
`define BIT_EXT_HEAT           7
`define BIT_LOCAL_OVERHEAT     6
`define BIT_PASSIVE_ZONE       5
`define BIT_LOCAL_CRIT         4
`define BIT_REMOTE_CRIT        3

`define OVERHEAT_HYST          8'h05
`define FAN_FAIL_COUNT         3'h5
`define SLOW_CNT_W             3

`endif

// [core/status_flags_pkg.sv]
// Purpose: Types shared by the status flag bank
// Assumes: Constants come from status_flags_cfg.svh
// Notes:   Measurement bundle is sampled once per monitoring cycle
package status_flags_pkg;

    typedef struct packed {
        logic [7:0]  remote_temp;
        logic [7:0]  remote_low_lim;
        logic [7:0]  remote_high_lim;
        logic [7:0]  remote_crit_lim;
        logic [7:0]  local_temp;
        logic [7:0]  local_heat_lim;
        logic [7:0]  local_crit_lim;
        logic [7:0]  control_temp;
        logic [7:0]  passive_cooling_temp;
        logic [15:0] speed_count;
        logic [15:0] speed_low_lim;
        logic [15:0] speed_high_lim;
    } measure_t;

    typedef struct packed {
        logic fan_range_irq_en;
        logic overheat_irq_en;
        logic passive_irq_en;
    } irq_en_t;

    typedef enum logic [2:0] {
        FAN_IDLE    = 3'h1,
        FAN_SPINUP  = 3'h2,
        FAN_MONITOR = 3'h4
    } fan_state_t;

endpackage

// [core/status_read_port.sv]
// Purpose: Registered read mux for the two status registers
// Assumes: One-cycle read strobe from the serial interface logic
// Notes:   Unmapped addresses read as zero
`timescale 1ns/100ps
`default_nettype none
`include "status_flags_cfg.svh"

module status_read_port (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_rd_stb,
    input  wire logic [7:0] i_rd_addr,
    input  wire logic [7:0] i_limit_fan,
    input  wire logic [7:0] i_critical,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_valid
);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data  <= `STATUS_RESET;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_stb;
            if (i_rd_stb) begin
                if (i_rd_addr == `LIMIT_FAN_STATUS_ADDR) begin
                    o_rd_data <= i_limit_fan;
                end else if (i_rd_addr == `CRITICAL_STATUS_ADDR) begin
                    o_rd_data <= i_critical;
                end else begin
                    o_rd_data <= `STATUS_RESET;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [core/thermal_fan_status_flags.sv]
// Purpose: Status flags, alert and alarm pins of a thermal fan monitor
// Assumes: Measurements and limits are stable when i_mon_tick pulses
// Notes:   Flags are read-to-clear; the read value is the pre-clear value
//
// Behaviour
// RULE1: Remote low flag sets when remote temperature at or below low limit.
// RULE2: Remote high flag sets when remote temperature at or above high limit.
// RULE3: Fan slow flag sets when speed count reaches the low limit.
// RULE4: Fan slow clears only by read; sets again next pass if still slow.
// RULE5: Spin-up completion sets fan slow flag, held until read.
// RULE6: Fan slow flag with fan range enable raises alert.
// RULE7: Five consecutive slow detections drive the fan failure pin low.
// RULE8: No slow detection while spin-up is in progress.
// RULE9: Overspeed flag sets when speed count at or below high limit.
// RULE10: Overspeed re-arms only after speed drops below the maximum.
// RULE11: Overspeed with enable raises alert but never fan failure.
// RULE12: Heat alarm pin low sets external heat flag and full fan.
// RULE13: Local above heat limit sets overheat flag; heat pin driven low.
// RULE14: Overheat flag with overheat enable raises alert.
// RULE15: After read, overheat re-arms only 5 degrees below the limit.
// RULE16: Passive flag sets when control temperature at or below passive temp.
// RULE17: Passive flag with enable raises alert; read clears it.
// RULE18: Local critical sets flag, over-temp pin low, unmaskable alert.
// RULE19: Remote critical sets flag, over-temp pin low, unmaskable alert.
// RULE20: Bits two to zero of the critical status read as zero.
// RULE21: Critical status sits at 0x03 and resets to zero.
// RULE22: Sticky bits hold until condition resolved and register read.
// RULE23: Conditions evaluated once per monitoring cycle, after read clears.
// RULE24: Alert held while any unmaskable or enabled flag is set.
`timescale 1ns/100ps
`default_nettype none
`include "status_flags_cfg.svh"

module thermal_fan_status_flags (
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_mon_tick,
    input  wire status_flags_pkg::measure_t i_meas,
    input  wire status_flags_pkg::irq_en_t i_irq_en,
    input  wire logic                      i_spinup_active,
    input  wire logic                      i_heat_alarm_in,
    input  wire logic                      i_rd_stb,
    input  wire logic [7:0]                i_rd_addr,
    output logic      [7:0]                o_rd_data,
    output logic                           o_rd_valid,
    output logic                           o_alert_n,
    output logic                           o_over_temp_out_n,
    output logic                           o_heat_alarm_pin_out,
    output logic                           o_heat_alarm_pin_oe_n,
    output logic                           o_fan_failure_pin_n,
    output logic                           o_fan_full_speed
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and event qualifiers

    logic       heat_meta;
    logic       heat_sync;
    logic       spin_meta;
    logic       spin_sync;
    logic       spin_prev;
    logic [7:0] limit_fan_status;
    logic [7:0] critical_status;
    logic       rd_limit_fan;
    logic       rd_critical;
    logic       spin_done;
    logic       speed_slow;
    logic       speed_fast;
    logic       overspeed_armed;
    logic       overheat_armed;
    logic [`SLOW_CNT_W-1:0] slow_run;
    logic       fan_failed;

    // Spin-up and heat alarm come from other timing domains
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            heat_meta <= 1'b1;
            heat_sync <= 1'b1;
            spin_meta <= 1'b0;
            spin_sync <= 1'b0;
            spin_prev <= 1'b0;
        end else begin
            heat_meta <= i_heat_alarm_in;
            heat_sync <= heat_meta;
            spin_meta <= i_spinup_active;
            spin_sync <= spin_meta;
            spin_prev <= spin_sync;
        end
    end

    function automatic logic at_or_below(input logic [7:0] a,
                                         input logic [7:0] b);
        at_or_below = (a <= b);
    endfunction

    assign rd_limit_fan = i_rd_stb && (i_rd_addr == `LIMIT_FAN_STATUS_ADDR);
    assign rd_critical  = i_rd_stb && (i_rd_addr == `CRITICAL_STATUS_ADDR);
    assign spin_done    = spin_prev && !spin_sync;
    assign speed_slow   = (i_meas.speed_count >= i_meas.speed_low_lim)
                          && !spin_sync; // RULE8
    assign speed_fast   = (i_meas.speed_count <= i_meas.speed_high_lim);

    ////////////////////////////////////////////////////////////////////////
    // Limit and fan status register (lower four bits)
    // Hardware set wins over a read clear in the same cycle.

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            limit_fan_status <= `STATUS_RESET;
        end else begin
            if (rd_limit_fan) begin
                limit_fan_status <= `STATUS_RESET; // RULE22
            end
            if (i_mon_tick) begin // RULE23
                if (at_or_below(i_meas.remote_temp,
                                i_meas.remote_low_lim)) begin
                    limit_fan_status[`BIT_REMOTE_LOW] <= 1'b1; // RULE1
                end
                if (!at_or_below(i_meas.remote_temp,
                                 i_meas.remote_high_lim)
                    || i_meas.remote_temp == i_meas.remote_high_lim) begin
                    limit_fan_status[`BIT_REMOTE_HIGH] <= 1'b1; // RULE2
                end
                if (speed_slow) begin
                    limit_fan_status[`BIT_FAN_SLOW] <= 1'b1; // RULE3 RULE4
                end
                if (speed_fast && overspeed_armed) begin
                    limit_fan_status[`BIT_OVERSPEED] <= 1'b1; // RULE9
                end
            end
            if (spin_done) begin
                limit_fan_status[`BIT_FAN_SLOW] <= 1'b1; // RULE5
            end
        end
    end

    // Overspeed may only fire again once the fan has slowed below maximum
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            overspeed_armed <= 1'b1;
        end else if (i_mon_tick && !speed_fast) begin
            overspeed_armed <= 1'b1; // RULE10
        end else if (rd_limit_fan
                     && limit_fan_status[`BIT_OVERSPEED]) begin
            overspeed_armed <= 1'b0; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fan failure: five consecutive slow detections

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slow_run   <= '0;
            fan_failed <= 1'b0;
        end else if (i_mon_tick && !spin_sync) begin
            if (speed_slow) begin
                if (slow_run != `FAN_FAIL_COUNT) begin
                    slow_run <= slow_run + 3'h1;
                end
                if (slow_run == `FAN_FAIL_COUNT - 3'h1) begin
                    fan_failed <= 1'b1; // RULE7
                end
            end else begin
                slow_run   <= '0;
                fan_failed <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Critical status register; bits two to zero are never stored

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            critical_status <= `STATUS_RESET; // RULE21
        end else begin
            if (rd_critical) begin
                critical_status <= `STATUS_RESET;
            end
            if (!heat_sync) begin
                critical_status[`BIT_EXT_HEAT] <= 1'b1; // RULE12
            end
            if (i_mon_tick) begin
                if (i_meas.local_temp > i_meas.local_heat_lim
                    && overheat_armed) begin
                    critical_status[`BIT_LOCAL_OVERHEAT] <= 1'b1; // RULE13
                end
                if (at_or_below(i_meas.control_temp,
                                i_meas.passive_cooling_temp)) begin
                    critical_status[`BIT_PASSIVE_ZONE] <= 1'b1; // RULE16
                end else begin
                    critical_status[`BIT_PASSIVE_ZONE] <= 1'b0; // RULE16
                end
                if (i_meas.local_temp >= i_meas.local_crit_lim) begin
                    critical_status[`BIT_LOCAL_CRIT] <= 1'b1; // RULE18
                end
                if (i_meas.remote_temp >= i_meas.remote_crit_lim) begin
                    critical_status[`BIT_REMOTE_CRIT] <= 1'b1; // RULE19
                end
            end
            critical_status[2:0] <= 3'h0; // RULE20
        end
    end

    // A cleared overheat flag waits for the hysteresis drop before re-arming
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            overheat_armed <= 1'b1;
        end else if (i_mon_tick
                     && ({1'b0, i_meas.local_temp} + {1'b0, `OVERHEAT_HYST}
                         <= {1'b0, i_meas.local_heat_lim})) begin
            overheat_armed <= 1'b1; // RULE15
        end else if (rd_critical
                     && critical_status[`BIT_LOCAL_OVERHEAT]) begin
            overheat_armed <= 1'b0; // RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pins, all registered

    logic next_alert;
    logic next_over_temp;

    always_comb begin
        next_alert =
            critical_status[`BIT_LOCAL_CRIT]                    // RULE18
            || critical_status[`BIT_REMOTE_CRIT]                // RULE19
            || (i_irq_en.fan_range_irq_en
                && (limit_fan_status[`BIT_FAN_SLOW]             // RULE6
                    || limit_fan_status[`BIT_OVERSPEED]))       // RULE11
            || (i_irq_en.overheat_irq_en
                && critical_status[`BIT_LOCAL_OVERHEAT])        // RULE14
            || (i_irq_en.passive_irq_en
                && critical_status[`BIT_PASSIVE_ZONE]);         // RULE17
        next_over_temp = critical_status[`BIT_LOCAL_CRIT]
                         || critical_status[`BIT_REMOTE_CRIT];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_alert_n             <= 1'b1;
            o_over_temp_out_n     <= 1'b1;
            o_heat_alarm_pin_out  <= 1'b0;
            o_heat_alarm_pin_oe_n <= 1'b1;
            o_fan_failure_pin_n   <= 1'b1;
            o_fan_full_speed      <= 1'b0;
        end else begin
            o_alert_n             <= !next_alert; // RULE24
            o_over_temp_out_n     <= !next_over_temp; // RULE18 RULE19
            o_heat_alarm_pin_out  <= 1'b0;
            // Open drain: enabled only to pull low
            o_heat_alarm_pin_oe_n <=
                !critical_status[`BIT_LOCAL_OVERHEAT]; // RULE13
            o_fan_failure_pin_n   <= !fan_failed; // RULE7 RULE11
            o_fan_full_speed      <= !heat_sync; // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read path

    status_read_port u_read (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_rd_stb    (i_rd_stb),
        .i_rd_addr   (i_rd_addr),
        .i_limit_fan (limit_fan_status),
        .i_critical  (critical_status),
        .o_rd_data   (o_rd_data),
        .o_rd_valid  (o_rd_valid)
    );

endmodule
`default_nettype wire

// [dv/thermal_fan_status_flags_asserts.sv]
// Purpose: Port-level checks on the status flag bank
// Assumes: Flags set on i_mon_tick, pins follow one cycle later
// Notes:   Each check ties an output to the input that causes it
`timescale 1ns/100ps
`default_nettype none
`include "status_flags_cfg.svh"

module thermal_fan_status_flags_asserts (
    input wire logic                       i_sys_clk,
    input wire logic                       i_rst_n,
    input wire logic                       i_mon_tick,
    input wire status_flags_pkg::measure_t i_meas,
    input wire logic                       i_heat_alarm_in,
    input wire logic                       i_rd_stb,
    input wire logic [7:0]                 i_rd_addr,
    input wire logic [7:0]                 o_rd_data,
    input wire logic                       o_rd_valid,
    input wire logic                       o_alert_n,
    input wire logic                       o_over_temp_out_n,
    input wire logic                       o_heat_alarm_pin_oe_n,
    input wire logic                       o_fan_failure_pin_n,
    input wire logic                       o_fan_full_speed
);
    logic slow_now;
    logic hot_now;
    logic lcrit;
    logic rcrit;
    assign slow_now = i_meas.speed_count >= i_meas.speed_low_lim;
    assign hot_now  = i_meas.local_temp > i_meas.local_heat_lim;
    assign lcrit    = i_meas.local_temp >= i_meas.local_crit_lim;
    assign rcrit    = i_meas.remote_temp >= i_meas.remote_crit_lim;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_rd_valid;
        i_rd_stb |=> o_rd_valid;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read answer missing");
    property p_rsvd_zero;
        i_rd_stb && i_rd_addr == `CRITICAL_STATUS_ADDR
            |=> o_rd_data[2:0] == 3'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bits not zero");
    property p_local_crit;
        i_mon_tick && lcrit |-> ##2 !o_over_temp_out_n;
    endproperty
    a_local_crit: assert property (p_local_crit)
        else $error("local critical pin not low");
    property p_remote_crit;
        i_mon_tick && rcrit |-> ##2 !o_over_temp_out_n;
    endproperty
    a_remote_crit: assert property (p_remote_crit)
        else $error("remote critical pin not low");
    property p_crit_alert;
        i_mon_tick && (lcrit || rcrit) |-> ##2 !o_alert_n;
    endproperty
    a_crit_alert: assert property (p_crit_alert)
        else $error("unmaskable alert missing");
    property p_fail_tick;
        $fell(o_fan_failure_pin_n) |-> $past(i_mon_tick, 2);
    endproperty
    a_fail_tick: assert property (p_fail_tick)
        else $error("fan failure without tick");
    property p_fail_slow;
        $fell(o_fan_failure_pin_n) |-> $past(slow_now, 2);
    endproperty
    a_fail_slow: assert property (p_fail_slow)
        else $error("fan failure without slow fan");
    property p_oe_cause;
        $fell(o_heat_alarm_pin_oe_n)
            |-> $past(i_mon_tick, 2) && $past(hot_now, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("heat pin driven without overheat");
    property p_full_on;
        !i_heat_alarm_in [*4] |-> o_fan_full_speed;
    endproperty
    a_full_on: assert property (p_full_on)
        else $error("full speed missing");
    property p_full_off;
        i_heat_alarm_in [*4] |-> !o_fan_full_speed;
    endproperty
    a_full_off: assert property (p_full_off)
        else $error("full speed stuck");
endmodule

bind thermal_fan_status_flags thermal_fan_status_flags_asserts u_chk (.*);
`default_nettype wire

// [dv/status_host_model.sv]
// Purpose: Host reader model for the status registers
// Assumes: Strobe taken on one edge, answer valid the cycle after
// Notes:   Idle address shows the inverse of the last one
`timescale 1ns/100ps
`default_nettype none

module status_host_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_data,
    output logic            o_rd_stb,
    output logic      [7:0] o_rd_addr
);
    initial begin
        o_rd_stb  = 1'b0;
        o_rd_addr = 8'h00;
    end

    task automatic read(input logic [7:0] addr, output logic [7:0] data,
                        output logic ok);
        @(posedge i_sys_clk);
        #1;
        o_rd_stb  = 1'b1;
        o_rd_addr = addr;
        @(posedge i_sys_clk);
        #1;
        ok        = i_rd_valid;
        data      = i_rd_data;
        o_rd_stb  = 1'b0;
        o_rd_addr = ~addr;
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the status flag bank
// Assumes: Both registers are read after each tick of the random and overheat loops
// Notes:   Bench tracks overspeed and overheat re-arm itself
`timescale 1ns/100ps
`default_nettype none
`include "status_flags_cfg.svh"

module tb_top;
    logic                       i_sys_clk;
    logic                       i_rst_n;
    logic                       tick_i;
    status_flags_pkg::measure_t meas;
    status_flags_pkg::irq_en_t  en;
    logic                       spinup;
    logic                       heat_in;
    logic                       rd_stb;
    logic [7:0]                 rd_addr;
    logic [7:0]                 rd_data;
    logic                       rd_valid;
    logic                       alert_n;
    logic                       otemp_n;
    logic                       oe_n;
    logic                       fail_n;
    logic                       full;
    logic                       pin_out;
    logic                       ovs_arm;
    logic                       oh_arm;
    logic                       al;
    logic [15:0]                e;
    logic [127:0]               r;
    logic [7:0]                 lt [7];
    logic [15:0]                sc [7];
    int                         fails = 0;
    int                         n_tests = 0;
    int                         cycles = 0;
    int                         seed = 32'hF307;

    thermal_fan_status_flags DUT (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mon_tick(tick_i),
        .i_meas(meas), .i_irq_en(en), .i_spinup_active(spinup),
        .i_heat_alarm_in(heat_in), .i_rd_stb(rd_stb), .i_rd_addr(rd_addr),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_alert_n(alert_n),
        .o_over_temp_out_n(otemp_n), .o_heat_alarm_pin_out(pin_out),
        .o_heat_alarm_pin_oe_n(oe_n), .o_fan_failure_pin_n(fail_n),
        .o_fan_full_speed(full));
    status_host_model u_host (
        .i_sys_clk(i_sys_clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
        .o_rd_stb(rd_stb), .o_rd_addr(rd_addr));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host.read(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d & m, exp);
    endtask

    // Outputs are one cycle behind the flags, so look two edges on
    task automatic tick();
        @(posedge i_sys_clk);
        #1 tick_i = 1'b1;
        @(posedge i_sys_clk);
        #1 tick_i = 1'b0;
        @(posedge i_sys_clk);
        #1;
    endtask

    function automatic logic [15:0] expect_regs(
        input status_flags_pkg::measure_t m);
        return {4'h0, m.remote_temp <= m.remote_low_lim,
                m.remote_temp >= m.remote_high_lim,
                m.speed_count >= m.speed_low_lim,
                ovs_arm && m.speed_count <= m.speed_high_lim,
                !heat_in, oh_arm && m.local_temp > m.local_heat_lim,
                m.control_temp <= m.passive_cooling_temp,
                m.local_temp >= m.local_crit_lim,
                m.remote_temp >= m.remote_crit_lim, 3'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        lt = '{8'h00, 8'h50, 8'h50, 8'h3C, 8'h50, 8'h3B, 8'h50};
        sc = '{16'h0020, 16'h0005, 16'h0005, 16'h0005, 16'h0010, 16'h0011,
               16'h0005};
        {i_rst_n, tick_i, spinup, meas, en} = '0;
        {heat_in, ovs_arm, oh_arm} = 3'h7;
        repeat (10) @(posedge i_sys_clk);
        #1 i_rst_n = 1'b1;
        check({3'h0, alert_n, otemp_n, oe_n, fail_n, full}, 8'h1E);
        rd_chk(`LIMIT_FAN_STATUS_ADDR, 8'hFF, 8'h00);
        rd_chk(`CRITICAL_STATUS_ADDR, 8'hFF, `STATUS_RESET);
        rd_chk(8'h05, 8'hFF, 8'h00);
        repeat (60) begin
            r = {$random(seed), $random(seed), $random(seed), $random(seed)};
            meas = r[119:0];
            meas.local_temp[7] = 1'b0;
            en = r[122:120];
            ovs_arm |= meas.speed_count > meas.speed_high_lim;
            oh_arm |= meas.local_temp + 8'h05 <= meas.local_heat_lim;
            e = expect_regs(meas);
            al = e[4] | e[3] | (en.fan_range_irq_en & (e[9] | e[8]));
            al = al | (en.overheat_irq_en & e[6]) | (en.passive_irq_en & e[5]);
            tick();
            check({4'h0, pin_out, alert_n, otemp_n, oe_n},
                  {4'h0, 1'b0, !al, !e[4] & !e[3], !e[6]});
            rd_chk(`LIMIT_FAN_STATUS_ADDR, 8'hFF, e[15:8]);
            rd_chk(`CRITICAL_STATUS_ADDR, 8'hFF, e[7:0]);
            ovs_arm &= !e[8];
            oh_arm &= !e[6];
        end
        meas = '0;
        meas.local_heat_lim = 8'h40;
        meas.speed_low_lim = 16'h0080;
        meas.speed_high_lim = 16'h0010;
        for (int i = 0; i < 7; i++) begin
            meas.local_temp = lt[i];
            meas.speed_count = sc[i];
            tick();
            al = (i % 5 == 1);
            rd_chk(`CRITICAL_STATUS_ADDR, 8'h40, {1'b0, al, 6'h00});
            rd_chk(`LIMIT_FAN_STATUS_ADDR, 8'h01, {7'h00, al});
        end
        for (int i = 0; i < 12; i++) begin
            meas.speed_count = (i < 6) ? 16'h0100 : 16'h0005;
            tick();
            check({7'h0, fail_n}, {7'h0, i < 4 || i > 5});
        end
        spinup = 1'b1;
        // Slow and overspeed stay latched from the failure run until read;
        // the read also gives the spin-up input time to pass the synchroniser
        rd_chk(`LIMIT_FAN_STATUS_ADDR, 8'h03, 8'h03);
        meas.speed_count = 16'h0100;
        tick();
        rd_chk(`LIMIT_FAN_STATUS_ADDR, 8'h02, 8'h00);
        meas.speed_count = 16'h0040;
        spinup = 1'b0;
        repeat (5) @(posedge i_sys_clk);
        rd_chk(`LIMIT_FAN_STATUS_ADDR, 8'h02, 8'h02);
        rd_chk(`LIMIT_FAN_STATUS_ADDR, 8'h02, 8'h00);
        heat_in = 1'b0;
        repeat (5) @(posedge i_sys_clk);
        #1 check({7'h0, full}, 8'h01);
        rd_chk(`CRITICAL_STATUS_ADDR, 8'h80, 8'h80);
        rd_chk(`CRITICAL_STATUS_ADDR, 8'h80, 8'h80);
        heat_in = 1'b1;
        repeat (5) @(posedge i_sys_clk);
        rd_chk(`CRITICAL_STATUS_ADDR, 8'h80, 8'h80);
        rd_chk(`CRITICAL_STATUS_ADDR, 8'h80, 8'h00);
        check({7'h0, full}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
